// ### logic/frs_pkg.sv
// Function
// - start-up timer runs after turn-on delay and ramp start; fault if threshold unmet.
// - start-up timeout limit counts in 10 us units.
// - start-up timeout takes ignore, latch-off or retry action.
// - start-up timeout acts at once, no deglitch.
// - limit of zero disables the start-up timeout check.
// - input overvoltage from adc result; adc latency is the deglitch; configured action.
// - above 130 C memory access disabled until 125 C reached.
// - warning flag bit 7 set above 130 C; clear refused until 125 C.
// - above 160 C switching stops until temperature falls to 150 C.
// - fault flag bit 6 set above 160 C; clear refused until 150 C.
// - internal temperature faults never ignored; thresholds fixed.
// - external over and under temperature each have own action.
// - input overcurrent and output undercurrent from adc, each with own action.
// - external fault pin low sets misc bit, vendor bit and alert, undeglitched.
// - external fault response is ignore or shut down then retry.
// - channel configuration bit 1 masks alert from the external fault pin.
// - log buffer refreshed continuously; copied to memory on disabling fault.
// - above 130 C log copy postponed until below 120 C.
// - stored log blocks further logging until clear command.
// - valid log at power-up sets status bit, raises alert, blocks logging.
// - external fault pin alone never starts a log capture.
// - retry waits programmed interval, 120 ms to 131.071 s in 1 ms steps.
package frs_pkg;
   // ****************************************
   // timing
   // ****************************************
   localparam int CLK_HZ          = 10_000_000;
   localparam int TICK_US         = 10;
   localparam int TICK_CYC        = CLK_HZ / 1_000_000 * TICK_US;
   localparam int MS_CYC          = CLK_HZ / 1000;
   localparam logic [16:0] RETRY_MIN_MS = 17'h00078;
   // ****************************************
   // temperature thresholds, degrees C
   // ****************************************
   localparam logic signed [9:0] NVM_OFF_C  = 10'sd130;
   localparam logic signed [9:0] NVM_ON_C   = 10'sd125;
   localparam logic signed [9:0] PWM_OFF_C  = 10'sd160;
   localparam logic signed [9:0] PWM_ON_C   = 10'sd150;
   localparam logic signed [9:0] LOG_ON_C   = 10'sd120;
   // ****************************************
   // bit positions
   // ****************************************
   localparam int TEMP_WARN_BIT   = 7;
   localparam int TEMP_FAULT_BIT  = 6;
   localparam int CFG_NO_ALERT_BIT = 1;
   localparam int VS_EXT_BIT      = 0;
   localparam int VS_LOG_BIT      = 1;
   // ****************************************
   // types
   // ****************************************
   typedef enum logic [1:0] {
      ACT_IGNORE = 2'h0,
      ACT_LATCH  = 2'h1,
      ACT_RETRY  = 2'h2
   } frs_act_t;
   // adc-derived fault indications, each already deglitched by conversion latency
   typedef struct packed {
      logic vin_ov;
      logic ext_ot;
      logic ext_ut;
      logic iin_oc;
      logic iout_uc;
   } frs_adc_t;
   typedef struct packed {
      frs_act_t startup;
      frs_act_t vin_ov;
      frs_act_t ext_ot;
      frs_act_t ext_ut;
      frs_act_t iin_oc;
      frs_act_t iout_uc;
   } frs_acts_t;
   typedef enum logic [3:0] {
      ST_IDLE  = 4'h1,
      ST_RUN   = 4'h2,
      ST_RETRY = 4'h4,
      ST_LATCH = 4'h8
   } frs_state_t;
endpackage

// ### logic/frs_supervisor.sv
module frs_supervisor
   import frs_pkg::*;
(
   input  wire logic               sys_clk,            // 10 MHz clock
   input  wire logic               srst,               // sync reset, high
   input  wire logic               enable,             // controller run request
   input  wire logic               ramp_started,       // turn-on delay over, ramp begun
   input  wire logic               vout_above_uv,      // output above undervoltage threshold
   input  wire logic [15:0]        startup_timeout_limit, // 10 us units, 0 = off
   input  wire logic [16:0]        retry_interval,     // ms
   input  wire frs_acts_t          actions,            // per-fault action
   input  wire logic               external_fault_action, // 0 ignore, 1 retry
   input  wire logic [7:0]         channel_configuration, // bit 1 masks pin alert
   input  wire frs_adc_t           adc_faults,         // adc-derived faults
   input  wire logic signed [9:0]  die_temp,           // internal temp, C
   input  wire logic               ext_fault_pin_n,    // external fault pin, low active
   input  wire logic               clear_faults,       // host clear pulse
   input  wire logic               fault_log_clear_cmd, // log clear pulse
   input  wire logic               nvm_log_valid,      // valid log found at power-up
   input  wire logic               nvm_copy_done,      // memory copy finished pulse
   output logic                    pwm_enable_ff,      // switching allowed
   output logic                    nvm_enable_ff,      // memory access allowed
   output logic [7:0]              temp_status_ff,     // temperature status
   output logic [7:0]              vendor_status_ff,   // vendor status
   output logic                    misc_fault_ff,      // summary misc bit
   output logic                    startup_fault_ff,   // start-up timeout flag
   output logic                    alert_n_ff,         // alert line, low active
   output logic                    log_refresh_ff,     // ram log refreshing
   output logic                    log_copy_ff         // copy ram log to memory
);
   // ****************************************
   // pin synchroniser
   // ****************************************
   logic ext_meta_ff, ext_sync_ff;
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         ext_meta_ff <= 1'b1;
         ext_sync_ff <= 1'b1;
      end else begin
         ext_meta_ff <= ext_fault_pin_n;
         ext_sync_ff <= ext_meta_ff;
      end
   end
   wire ext_low = ~ext_sync_ff;
   // ****************************************
   // timebases
   // ****************************************
   logic [7:0]  tick_cnt_ff;
   logic [15:0] ms_cnt_ff;
   logic        tick10_ff, ms_tick_ff;
   // start-up window closed: ramp not begun, output up or switching off
   wire         ton_hold = !ramp_started || vout_above_uv || !pwm_enable_ff;
   // 10 us enable restarts with the start-up window, so the first unit is whole;
   // a free-running divider would let the timeout fire up to one unit early
   always_ff @(posedge sys_clk) begin
      if (srst || ton_hold) begin
         tick_cnt_ff <= 8'h00;
         tick10_ff   <= 1'b0;
      end else begin
         tick10_ff   <= (tick_cnt_ff == 8'(TICK_CYC - 1));
         tick_cnt_ff <= (tick_cnt_ff == 8'(TICK_CYC - 1)) ? 8'h00 : tick_cnt_ff + 8'h01;
      end
   end
   // 1 ms enable for the retry wait; no second clock
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         ms_cnt_ff  <= 16'h0000;
         ms_tick_ff <= 1'b0;
      end else begin
         ms_tick_ff <= (ms_cnt_ff == 16'(MS_CYC - 1));
         ms_cnt_ff  <= (ms_cnt_ff == 16'(MS_CYC - 1)) ? 16'h0000 : ms_cnt_ff + 16'h0001;
      end
   end
   // ****************************************
   // internal temperature hysteresis
   // ****************************************
   logic nvm_hot_ff, pwm_hot_ff, log_hold_ff;
   // thresholds are fixed constants, no setting can change or ignore them
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         nvm_hot_ff  <= 1'b0;
         pwm_hot_ff  <= 1'b0;
         log_hold_ff <= 1'b0;
      end else begin
         if (die_temp > NVM_OFF_C)
            nvm_hot_ff <= 1'b1;
         else if (die_temp <= NVM_ON_C)
            nvm_hot_ff <= 1'b0;
         if (die_temp > PWM_OFF_C)
            pwm_hot_ff <= 1'b1;
         else if (die_temp <= PWM_ON_C)
            pwm_hot_ff <= 1'b0;
         if (die_temp > NVM_OFF_C)
            log_hold_ff <= 1'b1;
         else if (die_temp < LOG_ON_C)
            log_hold_ff <= 1'b0;
      end
   end
   always_ff @(posedge sys_clk) begin
      if (srst)
         nvm_enable_ff <= 1'b1;
      else
         nvm_enable_ff <= ~nvm_hot_ff;
   end
   // ****************************************
   // temperature status flags
   // ****************************************
   // set wins over clear; clear refused while still above release point
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         temp_status_ff <= 8'h00;
      end else begin
         if (die_temp > NVM_OFF_C)
            temp_status_ff[TEMP_WARN_BIT] <= 1'b1;
         else if (clear_faults && die_temp <= NVM_ON_C)
            temp_status_ff[TEMP_WARN_BIT] <= 1'b0;
         if (die_temp > PWM_OFF_C)
            temp_status_ff[TEMP_FAULT_BIT] <= 1'b1;
         else if (clear_faults && die_temp <= PWM_ON_C)
            temp_status_ff[TEMP_FAULT_BIT] <= 1'b0;
      end
   end
   // ****************************************
   // start-up timeout
   // ****************************************
   logic [15:0] ton_cnt_ff;
   logic        ton_arm_ff;
   wire         ton_expire = ton_arm_ff && tick10_ff && ~vout_above_uv
                             && (ton_cnt_ff == startup_timeout_limit - 16'h0001);
   // counter only runs once the ramp is under way; zero limit never arms
   // the limit is read live, so changing it mid-ramp moves the deadline
   always_ff @(posedge sys_clk) begin
      if (srst || ton_hold) begin
         ton_cnt_ff <= 16'h0000;
         ton_arm_ff <= 1'b0;
      end else begin
         ton_arm_ff <= (startup_timeout_limit != 16'h0000);
         if (ton_arm_ff && tick10_ff && !ton_expire)
            ton_cnt_ff <= ton_cnt_ff + 16'h0001;
      end
   end
   always_ff @(posedge sys_clk) begin
      if (srst)
         startup_fault_ff <= 1'b0;
      else if (ton_expire)
         startup_fault_ff <= 1'b1;
      else if (clear_faults)
         startup_fault_ff <= 1'b0;
   end
   // ****************************************
   // fault responses
   // ****************************************
   logic any_latch, any_retry;
   // startup acts same cycle as expiry: no filter on this path
   always_comb begin
      any_latch = 1'b0;
      any_retry = pwm_hot_ff;
      if (ton_expire) begin
         any_latch |= (actions.startup == ACT_LATCH);
         any_retry |= (actions.startup == ACT_RETRY);
      end
      if (adc_faults.vin_ov) begin
         any_latch |= (actions.vin_ov == ACT_LATCH);
         any_retry |= (actions.vin_ov == ACT_RETRY);
      end
      if (adc_faults.ext_ot) begin
         any_latch |= (actions.ext_ot == ACT_LATCH);
         any_retry |= (actions.ext_ot == ACT_RETRY);
      end
      if (adc_faults.ext_ut) begin
         any_latch |= (actions.ext_ut == ACT_LATCH);
         any_retry |= (actions.ext_ut == ACT_RETRY);
      end
      if (adc_faults.iin_oc) begin
         any_latch |= (actions.iin_oc == ACT_LATCH);
         any_retry |= (actions.iin_oc == ACT_RETRY);
      end
      if (adc_faults.iout_uc) begin
         any_latch |= (actions.iout_uc == ACT_LATCH);
         any_retry |= (actions.iout_uc == ACT_RETRY);
      end
   end
   wire pin_retry  = ext_low && external_fault_action;
   wire log_fault  = any_latch || any_retry;                  // pin excluded
   // ****************************************
   // run state machine
   // ****************************************
   frs_state_t  state_ff;
   logic [16:0] retry_ms_ff;
   // short intervals raised to the floor; first 1 ms step may be partial
   wire  [16:0] retry_eff = (retry_interval < RETRY_MIN_MS) ? RETRY_MIN_MS : retry_interval;
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         state_ff    <= ST_IDLE;
         retry_ms_ff <= 17'h00000;
      end else begin
         case (state_ff)
            ST_IDLE: begin
               if (enable && !pwm_hot_ff)
                  state_ff <= ST_RUN;
            end
            ST_RUN: begin
               retry_ms_ff <= 17'h00000;
               if (!enable)
                  state_ff <= ST_IDLE;
               else if (any_latch)
                  state_ff <= ST_LATCH;
               else if (any_retry || pin_retry)
                  state_ff <= ST_RETRY;
            end
            ST_RETRY: begin
               // latch fault during the wait still wins
               if (!enable)
                  state_ff <= ST_IDLE;
               else if (any_latch)
                  state_ff <= ST_LATCH;
               else if (any_retry || pin_retry)
                  retry_ms_ff <= 17'h00000;
               else if (ms_tick_ff) begin
                  if (retry_ms_ff >= retry_eff - 17'h00001)
                     state_ff <= ST_RUN;
                  else
                     retry_ms_ff <= retry_ms_ff + 17'h00001;
               end
            end
            ST_LATCH: begin
               if (clear_faults || !enable)
                  state_ff <= ST_IDLE;
            end
            default: state_ff <= ST_IDLE;
         endcase
      end
   end
   always_ff @(posedge sys_clk) begin
      if (srst)
         pwm_enable_ff <= 1'b0;
      else
         pwm_enable_ff <= (state_ff == ST_RUN) && !any_latch && !any_retry
                          && !pin_retry;
   end
   // ****************************************
   // external pin status and alert
   // ****************************************
   logic log_valid_ff, pwr_seen_ff;
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         misc_fault_ff    <= 1'b0;
         vendor_status_ff <= 8'h00;
      end else begin
         if (ext_low)
            misc_fault_ff <= 1'b1;
         else if (clear_faults)
            misc_fault_ff <= 1'b0;
         if (ext_low)
            vendor_status_ff[VS_EXT_BIT] <= 1'b1;
         else if (clear_faults)
            vendor_status_ff[VS_EXT_BIT] <= 1'b0;
         vendor_status_ff[VS_LOG_BIT] <= log_valid_ff;
      end
   end
   // alert sticks until host clears; pin source maskable
   // stored-log alert only from the power-up check, so a held valid
   // level cannot re-raise it after the host has cleared the log
   always_ff @(posedge sys_clk) begin
      if (srst)
         alert_n_ff <= 1'b1;
      else if ((ext_low && !channel_configuration[CFG_NO_ALERT_BIT])
               || ton_expire || (nvm_log_valid && !pwr_seen_ff))
         alert_n_ff <= 1'b0;
      else if (clear_faults)
         alert_n_ff <= 1'b1;
   end
   // ****************************************
   // fault log
   // ****************************************
   logic copy_pend_ff;
   // power-up check caught after reset release, not under reset
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         log_valid_ff <= 1'b0;
         pwr_seen_ff  <= 1'b0;
      end else begin
         pwr_seen_ff <= 1'b1;
         if (!pwr_seen_ff && nvm_log_valid)
            log_valid_ff <= 1'b1;
         else if (nvm_copy_done)
            log_valid_ff <= 1'b1;
         else if (fault_log_clear_cmd)
            log_valid_ff <= 1'b0;
      end
   end
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         copy_pend_ff   <= 1'b0;
         log_copy_ff    <= 1'b0;
         log_refresh_ff <= 1'b0;
      end else begin
         log_refresh_ff <= !log_valid_ff && !copy_pend_ff;
         if (log_fault && !log_valid_ff && state_ff == ST_RUN)
            copy_pend_ff <= 1'b1;
         else if (nvm_copy_done)
            copy_pend_ff <= 1'b0;
         log_copy_ff <= copy_pend_ff && !log_hold_ff && !nvm_copy_done;
      end
   end
endmodule

// ### bench/frs_stage_model.sv
module frs_stage_model (
   input  wire logic sys_clk,       // 10 MHz clock
   input  wire logic srst,          // sync reset, high
   input  wire logic pwm_on,        // switching allowed by the block
   input  wire logic slow,          // output stalls below threshold
   output logic      ramp_started,  // turn-on delay over, ramp running
   output logic      vout_above_uv  // output above undervoltage level
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] ramp_cnt_ff;
   // cycles since switching began; saturates so a long run never wraps
   always_ff @(posedge sys_clk) begin
      if (srst || !pwm_on) ramp_cnt_ff <= 8'h00;
      else if (ramp_cnt_ff != 8'hFF) ramp_cnt_ff <= ramp_cnt_ff + 8'h01;
   end
   // short turn-on delay, then a ramp of twenty cycles unless stalled
   assign ramp_started  = ramp_cnt_ff >= 8'h04;
   assign vout_above_uv = !slow && ramp_cnt_ff >= 8'h18;
endmodule

// ### bench/frs_supervisor_chk.sv
module frs_supervisor_chk
   import frs_pkg::*;
(
   input wire logic              sys_clk,               // clock
   input wire logic              srst,                  // sync reset
   input wire logic              ramp_started,          // ramp running
   input wire logic              vout_above_uv,         // output up
   input wire logic [15:0]       startup_timeout_limit, // 10 us units
   input wire frs_acts_t         actions,               // per-fault action
   input wire logic              clear_faults,          // clear pulse
   input wire logic [7:0]        channel_configuration, // alert mask
   input wire logic signed [9:0] die_temp,              // internal temp
   input wire logic              ext_fault_pin_n,       // pin, low active
   input wire logic              pwm_enable_ff,         // switching
   input wire logic              nvm_enable_ff,         // memory access
   input wire logic [7:0]        temp_status_ff,        // temp status
   input wire logic [7:0]        vendor_status_ff,      // vendor status
   input wire logic              misc_fault_ff,         // summary bit
   input wire logic              startup_fault_ff,      // timeout flag
   input wire logic              alert_n_ff,            // alert line
   input wire logic              log_copy_ff            // log copy request
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);
   int run_cnt;
   int lim_cyc;
   // cycles of ramp without the output up; the 10 us enable restarts with it
   assign lim_cyc = int'(startup_timeout_limit) * TICK_CYC;
   always_ff @(posedge sys_clk) begin
      if (srst || !ramp_started || vout_above_uv) run_cnt <= 0;
      else run_cnt <= run_cnt + 1;
   end
   sequence s_pin_low;
      !ext_fault_pin_n ##1 !ext_fault_pin_n;
   endsequence
   sequence s_latched;
      startup_fault_ff && !pwm_enable_ff && actions.startup == ACT_LATCH && !clear_faults;
   endsequence
   a_pin_flags: assert property (s_pin_low |-> ##[1:3] (misc_fault_ff && vendor_status_ff[0]))
      else $error("pin fault flags not set");
   a_pin_alert: assert property (s_pin_low ##0 !channel_configuration[1] |-> ##[1:3] !alert_n_ff)
      else $error("pin fault alert missing");
   a_nvm_off: assert property (die_temp > NVM_OFF_C |-> ##[1:3] !nvm_enable_ff)
      else $error("memory access left on when hot");
   a_nvm_hold: assert property (!nvm_enable_ff && die_temp > NVM_ON_C |=> !nvm_enable_ff)
      else $error("memory access back too early");
   a_warn_set: assert property (die_temp > NVM_OFF_C |-> ##[1:3] temp_status_ff[7])
      else $error("warning flag not set");
   a_warn_keep: assert property (temp_status_ff[7] && die_temp > NVM_ON_C |=> temp_status_ff[7])
      else $error("warning flag cleared while hot");
   a_pwm_hot: assert property (die_temp > PWM_OFF_C |-> ##[1:3] (!pwm_enable_ff && temp_status_ff[6]))
      else $error("switching not stopped when hot");
   a_fault_keep: assert property (temp_status_ff[6] && die_temp > PWM_ON_C |=> temp_status_ff[6])
      else $error("fault flag cleared while hot");
   a_limit_time: assert property ($rose(startup_fault_ff) |-> startup_timeout_limit != 16'h0000
      && run_cnt >= lim_cyc && run_cnt <= lim_cyc + 6)
      else $error("start-up timeout at wrong time");
   a_latch_stays: assert property (s_latched |=> !pwm_enable_ff)
      else $error("latched shutdown restarted");
   a_copy_gate: assert property (vendor_status_ff[1] && !log_copy_ff |=> !log_copy_ff)
      else $error("log copied over a stored log");
endmodule
bind frs_supervisor frs_supervisor_chk i_frs_supervisor_chk (
   .sys_clk, .srst, .ramp_started, .vout_above_uv, .startup_timeout_limit, .actions,
   .clear_faults, .channel_configuration, .die_temp, .ext_fault_pin_n, .pwm_enable_ff,
   .nvm_enable_ff, .temp_status_ff, .vendor_status_ff, .misc_fault_ff, .startup_fault_ff,
   .alert_n_ff, .log_copy_ff
);

// ### bench/test_frs_supervisor.sv
module test_frs_supervisor
   import frs_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ns;
   `define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin num_errors++; \
      $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
   logic              sys_clk = 1'b0, srst = 1'b1, enable = 1'b0, slow = 1'b0;
   logic              ext_fault_pin_n = 1'b1, external_fault_action = 1'b0;
   logic              clear_faults = 1'b0, fault_log_clear_cmd = 1'b0;
   logic              nvm_log_valid = 1'b0, nvm_copy_done = 1'b0;
   logic [15:0]       startup_timeout_limit = 16'h0002;
   logic [16:0]       retry_interval = 17'h00078;
   logic [7:0]        channel_configuration = 8'h00;
   logic signed [9:0] die_temp = 10'h019;
   frs_acts_t         actions = '0;
   frs_adc_t          adc_faults = '0;
   logic              ramp_started, vout_above_uv, pwm_enable_ff, nvm_enable_ff;
   logic              misc_fault_ff, startup_fault_ff, alert_n_ff, log_copy_ff, log_refresh_ff;
   logic [7:0]        temp_status_ff, vendor_status_ff;
   int                num_errors = 0, cmp_count = 0, tcnt = 0, n;
   frs_supervisor i_frs_supervisor (
      .sys_clk, .srst, .enable, .ramp_started, .vout_above_uv, .startup_timeout_limit,
      .retry_interval, .actions, .external_fault_action, .channel_configuration,
      .adc_faults, .die_temp, .ext_fault_pin_n, .clear_faults, .fault_log_clear_cmd,
      .nvm_log_valid, .nvm_copy_done, .pwm_enable_ff, .nvm_enable_ff, .temp_status_ff,
      .vendor_status_ff, .misc_fault_ff, .startup_fault_ff, .alert_n_ff,
      .log_refresh_ff, .log_copy_ff);
   frs_stage_model i_frs_stage_model (.sys_clk, .srst, .pwm_on(pwm_enable_ff), .slow,
      .ramp_started, .vout_above_uv);
   // ********************
   // clock, watchdog, helpers
   // ********************
   // ********************
   initial forever #50 sys_clk = ~sys_clk;
   // the whole run needs about 4060 cycles; a hang stops well past that
   always @(posedge sys_clk) begin
      tcnt++;
      if (tcnt == 12000) begin
         num_errors++;
         close_out();
      end
   end
   task close_out;
      if (num_errors == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task cyc(input int k);
      repeat (k) @(negedge sys_clk);
   endtask
   task rst;
      srst = 1'b1;
      cyc(5);
      srst = 1'b0;
      cyc(2);
   endtask
   task run_up;
      rst();
      enable = 1'b1;
      cyc(30);
   endtask
   // one-cycle host pulses: 0 clear faults, 1 clear log, 2 copy done
   task pulse(input int k);
      case (k)
         0: clear_faults = 1'b1;
         1: fault_log_clear_cmd = 1'b1;
         default: nvm_copy_done = 1'b1;
      endcase
      cyc(1);
      {clear_faults, fault_log_clear_cmd, nvm_copy_done} = 3'h0;
   endtask
   task wait_sf;
      n = 0;
      while (startup_fault_ff !== 1'b1 && n < 400) begin
         cyc(1);
         n++;
      end
   endtask
   // ********************
   // scenarios
   // ********************
   initial begin
      rst();
      `CHK({pwm_enable_ff, nvm_enable_ff, alert_n_ff, log_copy_ff, log_refresh_ff}, 5'h0D)
      `CHK(vendor_status_ff | temp_status_ff, 8'h00)
      nvm_log_valid = 1'b1;
      rst();
      `CHK({vendor_status_ff[VS_LOG_BIT], alert_n_ff, log_refresh_ff}, 3'h4)
      nvm_log_valid = 1'b0;
      pulse(1);
      cyc(1);
      `CHK(vendor_status_ff[VS_LOG_BIT], 1'b0)
      // stalled output: each start-up timeout action in turn
      slow = 1'b1;
      for (int a = 0; a < 3; a++) begin
         rst();
         actions.startup = frs_act_t'(a);
         enable = 1'b1;
         wait_sf();
         `CHK(n >= 2 * TICK_CYC && n <= 2 * TICK_CYC + 20, 1'b1)
         cyc(3);
         `CHK({pwm_enable_ff, alert_n_ff, log_copy_ff}, {a == 0, 1'b0, a != 0})
         cyc(600);
         `CHK(pwm_enable_ff, a == 0)
         if (a == 1) begin
            pulse(2);
            cyc(1);
            `CHK({vendor_status_ff[VS_LOG_BIT], log_copy_ff}, 2'h2)
            pulse(0);
            cyc(3);
            `CHK(pwm_enable_ff, 1'b1)
            wait_sf();
            cyc(3);
            `CHK({pwm_enable_ff, log_copy_ff}, 2'h0)
            pulse(1);
            cyc(1);
            `CHK(vendor_status_ff[VS_LOG_BIT], 1'b0)
         end
      end
      startup_timeout_limit = 16'h0000;
      rst();
      cyc(600);
      `CHK({startup_fault_ff, pwm_enable_ff}, 2'h1)
      // limit well past the ramp from here on
      startup_timeout_limit = 16'h0005;
      slow = 1'b0;
      // adc faults, first ignored, then latched, then retried
      for (int m = 0; m < 3; m++) begin
         for (int i = 0; i < 5; i++) begin
            actions = frs_acts_t'({6{m[1:0]}});
            run_up();
            adc_faults = frs_adc_t'(5'h01 << i);
            cyc(4);
            adc_faults = '0;
            `CHK({pwm_enable_ff, log_copy_ff}, {m == 0, m != 0})
         end
      end
      // pin fault: unmasked and ignored, then masked with retry
      actions = '0;
      for (int c = 0; c < 2; c++) begin
         channel_configuration = {6'h00, c[0], 1'b0};
         external_fault_action = c[0];
         run_up();
         ext_fault_pin_n = 1'b0;
         cyc(5);
         ext_fault_pin_n = 1'b1;
         `CHK({misc_fault_ff, vendor_status_ff[VS_EXT_BIT], alert_n_ff}, {2'h3, c[0]})
         `CHK({pwm_enable_ff, log_copy_ff}, {!c[0], 1'b0})
      end
      // die heating and cooling; clears above release are refused
      channel_configuration = 8'h00;
      external_fault_action = 1'b0;
      run_up();
      die_temp = 10'h083;
      cyc(4);
      `CHK({nvm_enable_ff, temp_status_ff[TEMP_WARN_BIT], pwm_enable_ff}, 3'h3)
      die_temp = 10'h07E;
      pulse(0);
      cyc(2);
      `CHK({nvm_enable_ff, temp_status_ff[TEMP_WARN_BIT]}, 2'h1)
      die_temp = 10'h07D;
      cyc(3);
      pulse(0);
      cyc(2);
      `CHK({nvm_enable_ff, temp_status_ff[TEMP_WARN_BIT]}, 2'h2)
      die_temp = 10'h0A1;
      cyc(4);
      `CHK({pwm_enable_ff, temp_status_ff[TEMP_FAULT_BIT], log_copy_ff}, 3'h2)
      die_temp = 10'h09B;
      pulse(0);
      cyc(2);
      `CHK({pwm_enable_ff, temp_status_ff[TEMP_FAULT_BIT]}, 2'h1)
      die_temp = 10'h096;
      cyc(3);
      pulse(0);
      cyc(2);
      `CHK(temp_status_ff[TEMP_FAULT_BIT], 1'b0)
      die_temp = 10'h07D;
      cyc(3);
      `CHK(log_copy_ff, 1'b0)
      die_temp = 10'h077;
      cyc(3);
      `CHK(log_copy_ff, 1'b1)
      close_out();
   end
endmodule
